// *** common/cbs_cfg.svh ***
`ifndef CBS_CFG_SVH
`define CBS_CFG_SVH
// interrupt acknowledge byte enables, first and second read
`define CBS_IRQ_BE_FIRST 8'hEF
`define CBS_IRQ_BE_SECOND 8'hFE
// writeback line transfer: index of the last of four beats
`define CBS_WB_LAST_BEAT 2'h3
// clocks of address hold needed before a snoop strobe counts
`define CBS_ADDR_HOLD_REQ_MIN 2'h2
// writeback drives all byte lanes
`define CBS_WB_BE 8'h00
`define CBS_BE_RST 8'hFF
`define CBS_ADDR_RST 29'h0000_0000
`define CBS_DATA_RST 64'h0000_0000_0000_0000
`endif

// *** common/cbs_pkg.sv ***
package cbs_pkg;
  typedef enum logic [1:0] {
    CBS_IDLE = 2'b00,
    CBS_T1 = 2'b01,
    CBS_T2 = 2'b10,
    CBS_HOLD = 2'b11
  } cbs_state_t;
  typedef enum logic [1:0] {
    CBS_IRQ_NONE = 2'b00,
    CBS_IRQ_FIRST = 2'b01,
    CBS_IRQ_SECOND = 2'b10
  } cbs_irq_t;
endpackage

// *** src/cbs_bus_unit.sv ***
// Notes on behaviour
// - clean snoop hit: hit asserted, dirty negated
// - sample hold each edge; start on release
// - dirty snoop hit asserts both hit signals
// - writeback dirty line before any new cycle
// - address undriven during writeback under hold
// - writeback uses snoop-latched line address
// - invalidate flag picks invalid or shared state
// - backoff aborts everything, floats bus, holds
// - restart on edge backoff seen negated
// - writeback before restart, lock kept asserted
// - lock spans sequence, gap between sequences
// - flush operands before lock, no caching
// - misaligned locked: split flag, extra cycle
// - interrupt acknowledge as locked read pair
// - float address on hold, finish cycle
`include "cbs_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module cbs_bus_unit (
  input wire logic clk, // bus clock
  input wire logic rst_n, // async reset
  input wire logic ce, // clock enable
  input wire logic addr_hold_req, // address hold request
  input wire logic ext_addr_strobe_n, // snoop address strobe
  input wire logic snoop_invalidate, // snoop invalidate
  input wire logic backoff_n, // backoff
  input wire logic burst_ready_n, // transfer ready
  input wire logic cache_enable_n, // cacheable return
  input wire logic [31:3] addr_in, // address bus in
  input wire logic [63:0] data_in, // data bus in
  output logic [31:3] addr_out, // address bus out
  output logic addr_parity, // address parity
  output logic addr_oe_n, // address enable, low drives
  output logic addr_strobe_n, // cycle strobe
  output logic [7:0] byte_enables_n, // byte enables
  output logic data_code_sel, // data or code
  output logic mem_io_sel, // memory or io
  output logic write_read_sel, // write or read
  output logic bus_lock_n, // bus lock
  output logic split_cycle_ind, // split cycle
  output logic ctrl_oe_n, // control enable, low drives
  output logic [63:0] data_out, // data bus out
  output logic data_oe_n, // data enable, low drives
  output logic snoop_hit_n, // snoop hit
  output logic snoop_dirty_hit_n, // snoop modified hit
  input wire logic lookup_hit, // cache: addr_in line present
  input wire logic lookup_dirty, // cache: addr_in line modified
  input wire logic [255:0] wb_line, // cache: line at snoop address
  output logic line_upd, // cache: change line state
  output logic line_upd_inv, // 1 invalid, 0 shared
  output logic [31:5] line_upd_addr, // line to change
  input wire logic req_valid, // core cycle request
  output logic req_ready, // request taken
  input wire logic [31:3] req_addr, // request address
  input wire logic [7:0] req_be_n, // request enables
  input wire logic [7:0] req_be2_n, // enables, second half
  input wire logic req_write, // write
  input wire logic req_dc, // data or code
  input wire logic req_mio, // memory or io
  input wire logic [63:0] req_wdata, // write data
  input wire logic req_lock, // part of locked sequence
  input wire logic req_lock_last, // last of sequence
  input wire logic req_split, // misaligned, two cycles when req_lock is set
  output logic lock_flush_req, // flush lock operands
  input wire logic lock_flush_done, // flush finished
  output logic req_done, // request finished
  output logic [63:0] rd_data, // read data
  output logic rd_cacheable, // read data may be cached
  input wire logic maskable_irq, // maskable interrupt
  input wire logic irq_boundary, // instruction boundary
  output logic irq_vec_valid, // vector pulse
  output logic [7:0] irq_vec // interrupt vector
);
  cbs_pkg::cbs_state_t state_reg, state_next;
  cbs_pkg::cbs_irq_t irq_reg, irq_next;
  logic ah_s_reg, ah_s_next;
  logic [1:0] ah_cnt_reg, ah_cnt_next;
  logic hit_n_reg, hit_n_next, dhit_n_reg, dhit_n_next;
  logic [31:5] snp_reg, snp_next;
  logic wb_pend_reg, wb_pend_next, wb_run_reg, wb_run_next;
  logic inv_s_reg, inv_s_next;
  logic rst_pend_reg, rst_pend_next;
  logic upd_reg, upd_next, upd_inv_reg, upd_inv_next;
  logic [31:3] cur_addr_reg, cur_addr_next;
  logic [7:0] cur_be_reg, cur_be_next, cur_be2_reg, cur_be2_next;
  logic cur_wr_reg, cur_wr_next, cur_dc_reg, cur_dc_next;
  logic cur_mio_reg, cur_mio_next, cur_lock_reg, cur_lock_next;
  logic cur_last_reg, cur_last_next, cur_split_reg, cur_split_next;
  logic split2_reg, split2_next, cur_irq_reg, cur_irq_next;
  logic cur_core_reg, cur_core_next;
  logic [63:0] wdata_reg, wdata_next;
  logic [1:0] beat_reg, beat_next;
  logic lock_n_reg, lock_n_next;
  logic [31:3] addr_reg, addr_next;
  logic [7:0] be_reg, be_next;
  logic dc_reg, dc_next, mio_reg, mio_next, wr_reg, wr_next;
  logic split_cycle_ind_reg, split_cycle_ind_next;
  logic [63:0] dout_reg, dout_next, rdata_reg, rdata_next;
  logic done_reg, done_next, cach_reg, cach_next;
  logic [7:0] vec_reg, vec_next;
  logic vec_v_reg, vec_v_next;
  logic can_start, go_wb, go_rst, go_irq, go_req, lock_ok, snoop_ok;
  logic last_beat;

  ////////////////////////////////////////////////////////////////////////
  // launch arbitration
  // no new cycle from idle while address hold is sampled
  assign can_start = (state_reg == cbs_pkg::CBS_IDLE && !addr_hold_req &&
                      backoff_n) ||
                     (state_reg == cbs_pkg::CBS_HOLD && backoff_n);
  // locked sequence waits for operand flush
  assign lock_ok = !req_lock || !lock_n_reg || lock_flush_done;
  // pending writeback goes ahead of any cycle
  assign go_wb = can_start && wb_pend_reg;
  // writeback first, then the aborted cycle
  assign go_rst = can_start && !wb_pend_reg && rst_pend_reg;
  assign go_irq = can_start && !wb_pend_reg && !rst_pend_reg &&
                  irq_reg != cbs_pkg::CBS_IRQ_NONE;
  assign go_req = can_start && !wb_pend_reg && !rst_pend_reg &&
                  irq_reg == cbs_pkg::CBS_IRQ_NONE && req_valid && lock_ok;
  assign req_ready = go_req;
  assign lock_flush_req = req_valid && req_lock && lock_n_reg &&
                          !lock_flush_done;
  // snoop needs two sampled hold clocks or a backoff hold
  assign snoop_ok = !ext_addr_strobe_n &&
                    (ah_cnt_reg == `CBS_ADDR_HOLD_REQ_MIN ||
                     state_reg == cbs_pkg::CBS_HOLD);
  assign last_beat = wb_run_reg ? (beat_reg == `CBS_WB_LAST_BEAT) : 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    state_next = state_reg;
    irq_next = irq_reg;
    ah_s_next = addr_hold_req;
    ah_cnt_next = 2'h0;
    hit_n_next = hit_n_reg;
    dhit_n_next = dhit_n_reg;
    snp_next = snp_reg;
    wb_pend_next = wb_pend_reg;
    wb_run_next = wb_run_reg;
    inv_s_next = inv_s_reg;
    rst_pend_next = rst_pend_reg;
    upd_next = 1'b0;
    upd_inv_next = upd_inv_reg;
    cur_addr_next = cur_addr_reg;
    cur_be_next = cur_be_reg;
    cur_be2_next = cur_be2_reg;
    cur_wr_next = cur_wr_reg;
    cur_dc_next = cur_dc_reg;
    cur_mio_next = cur_mio_reg;
    cur_lock_next = cur_lock_reg;
    cur_last_next = cur_last_reg;
    cur_split_next = cur_split_reg;
    split2_next = split2_reg;
    cur_irq_next = cur_irq_reg;
    cur_core_next = cur_core_reg;
    wdata_next = wdata_reg;
    beat_next = beat_reg;
    lock_n_next = lock_n_reg;
    addr_next = addr_reg;
    be_next = be_reg;
    dc_next = dc_reg;
    mio_next = mio_reg;
    wr_next = wr_reg;
    split_cycle_ind_next = split_cycle_ind_reg;
    dout_next = dout_reg;
    rdata_next = rdata_reg;
    done_next = 1'b0;
    cach_next = cach_reg;
    vec_next = vec_reg;
    vec_v_next = 1'b0;
    if (addr_hold_req)
    begin
      ah_cnt_next = (ah_cnt_reg == `CBS_ADDR_HOLD_REQ_MIN) ? ah_cnt_reg :
                    ah_cnt_reg + 2'h1;
    end
    if (irq_reg == cbs_pkg::CBS_IRQ_NONE && maskable_irq && irq_boundary)
      irq_next = cbs_pkg::CBS_IRQ_FIRST;
    if (go_irq)
    begin
      cur_addr_next = `CBS_ADDR_RST;
      cur_be_next = (irq_reg == cbs_pkg::CBS_IRQ_FIRST) ?
                    `CBS_IRQ_BE_FIRST : `CBS_IRQ_BE_SECOND;
      cur_wr_next = 1'b0;
      cur_dc_next = 1'b0;
      cur_mio_next = 1'b0;
      cur_lock_next = 1'b1;
      cur_last_next = (irq_reg == cbs_pkg::CBS_IRQ_SECOND);
      cur_split_next = 1'b0;
      cur_irq_next = 1'b1;
      cur_core_next = 1'b0;
    end
    if (go_req)
    begin
      cur_addr_next = req_addr;
      cur_be_next = req_be_n;
      cur_be2_next = req_be2_n;
      cur_wr_next = req_write;
      cur_dc_next = req_dc;
      cur_mio_next = req_mio;
      cur_lock_next = req_lock;
      cur_last_next = req_lock_last;
      cur_split_next = req_split && req_lock;
      split2_next = 1'b0;
      cur_irq_next = 1'b0;
      cur_core_next = 1'b1;
      wdata_next = req_wdata;
    end
    if (go_rst)
      rst_pend_next = 1'b0;
    if (go_wb)
    begin
      // writeback address from the snoop latch
      wb_run_next = 1'b1;
      addr_next = {snp_reg, 2'b00};
      be_next = `CBS_WB_BE;
      dc_next = 1'b1;
      mio_next = 1'b1;
      wr_next = 1'b1;
      split_cycle_ind_next = 1'b0;
      dout_next = wb_line[63:0];
    end
    else if (go_rst || go_irq || go_req)
    begin
      // restart reissues the held cycle attributes
      addr_next = cur_addr_next;
      be_next = cur_be_next;
      dc_next = cur_dc_next;
      mio_next = cur_mio_next;
      wr_next = cur_wr_next;
      // split flag on misaligned locked transfers
      split_cycle_ind_next = cur_split_next;
      dout_next = wdata_next;
      // lock goes low with the first strobe
      if (cur_lock_next)
        lock_n_next = 1'b0;
    end
    if (go_wb || go_rst || go_irq || go_req)
    begin
      state_next = cbs_pkg::CBS_T1;
      beat_next = 2'h0;
    end
    else if (state_reg == cbs_pkg::CBS_HOLD && backoff_n)
      state_next = cbs_pkg::CBS_IDLE;
    unique case (state_reg)
      cbs_pkg::CBS_IDLE:
      begin
        if (!backoff_n)
          state_next = cbs_pkg::CBS_HOLD;
      end
      cbs_pkg::CBS_T1, cbs_pkg::CBS_T2:
      begin
        // backoff wins over a ready on the same edge
        if (!backoff_n)
        begin
          state_next = cbs_pkg::CBS_HOLD;
          beat_next = 2'h0;
          if (!wb_run_reg)
            rst_pend_next = 1'b1;
          wb_run_next = 1'b0;
        end
        else if (state_reg == cbs_pkg::CBS_T1)
          state_next = cbs_pkg::CBS_T2;
        else if (!burst_ready_n && !last_beat)
        begin
          beat_next = beat_reg + 2'h1;
          dout_next = wb_line[{beat_next, 6'h00} +: 64];
        end
        else if (!burst_ready_n)
        begin
          state_next = cbs_pkg::CBS_IDLE;
          if (wb_run_reg)
          begin
            // state changes only after the writeback
            wb_run_next = 1'b0;
            wb_pend_next = 1'b0;
            dhit_n_next = 1'b1;
            upd_next = 1'b1;
            upd_inv_next = inv_s_reg;
          end
          else if (cur_split_reg && !split2_reg)
          begin
            // second half as an extra locked cycle
            split2_next = 1'b1;
            cur_addr_next = cur_addr_reg + 29'h0000_0001;
            cur_be_next = cur_be2_reg;
            rst_pend_next = 1'b1;
          end
          else
          begin
            // lock released on the final ready
            if (cur_last_reg)
              lock_n_next = 1'b1;
            if (cur_irq_reg)
            begin
              irq_next = cur_last_reg ? cbs_pkg::CBS_IRQ_NONE :
                         cbs_pkg::CBS_IRQ_SECOND;
              vec_v_next = cur_last_reg;
              if (cur_last_reg)
                vec_next = data_in[7:0];
            end
            done_next = cur_core_reg;
            rdata_next = data_in;
            cach_next = !cache_enable_n && !cur_lock_reg;
          end
        end
      end
      cbs_pkg::CBS_HOLD:
      begin
      end
    endcase
    if (snoop_ok)
    begin
      snp_next = addr_in[31:5];
      // hit level holds until the next snoop; dirty hit clears when the writeback ends
      hit_n_next = !lookup_hit;
      dhit_n_next = !(lookup_hit && lookup_dirty);
      if (lookup_hit && lookup_dirty)
      begin
        wb_pend_next = 1'b1;
        inv_s_next = snoop_invalidate;
      end
      // clean hit changes state with no bus cycle
      else if (lookup_hit)
      begin
        upd_next = 1'b1;
        upd_inv_next = snoop_invalidate;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= cbs_pkg::CBS_IDLE;
      irq_reg <= cbs_pkg::CBS_IRQ_NONE;
      ah_s_reg <= 1'b0;
      ah_cnt_reg <= 2'h0;
      hit_n_reg <= 1'b1;
      dhit_n_reg <= 1'b1;
      snp_reg <= 27'h000_0000;
      wb_pend_reg <= 1'b0;
      wb_run_reg <= 1'b0;
      inv_s_reg <= 1'b0;
      rst_pend_reg <= 1'b0;
      upd_reg <= 1'b0;
      upd_inv_reg <= 1'b0;
      cur_addr_reg <= `CBS_ADDR_RST;
      cur_be_reg <= `CBS_BE_RST;
      cur_be2_reg <= `CBS_BE_RST;
      cur_wr_reg <= 1'b0;
      cur_dc_reg <= 1'b0;
      cur_mio_reg <= 1'b0;
      cur_lock_reg <= 1'b0;
      cur_last_reg <= 1'b0;
      cur_split_reg <= 1'b0;
      split2_reg <= 1'b0;
      cur_irq_reg <= 1'b0;
      cur_core_reg <= 1'b0;
      wdata_reg <= `CBS_DATA_RST;
      beat_reg <= 2'h0;
      lock_n_reg <= 1'b1;
      addr_reg <= `CBS_ADDR_RST;
      be_reg <= `CBS_BE_RST;
      dc_reg <= 1'b0;
      mio_reg <= 1'b0;
      wr_reg <= 1'b0;
      split_cycle_ind_reg <= 1'b0;
      dout_reg <= `CBS_DATA_RST;
      rdata_reg <= `CBS_DATA_RST;
      done_reg <= 1'b0;
      cach_reg <= 1'b0;
      vec_reg <= 8'h00;
      vec_v_reg <= 1'b0;
    end
    else if (ce)
    begin
      state_reg <= state_next;
      irq_reg <= irq_next;
      ah_s_reg <= ah_s_next;
      ah_cnt_reg <= ah_cnt_next;
      hit_n_reg <= hit_n_next;
      dhit_n_reg <= dhit_n_next;
      snp_reg <= snp_next;
      wb_pend_reg <= wb_pend_next;
      wb_run_reg <= wb_run_next;
      inv_s_reg <= inv_s_next;
      rst_pend_reg <= rst_pend_next;
      upd_reg <= upd_next;
      upd_inv_reg <= upd_inv_next;
      cur_addr_reg <= cur_addr_next;
      cur_be_reg <= cur_be_next;
      cur_be2_reg <= cur_be2_next;
      cur_wr_reg <= cur_wr_next;
      cur_dc_reg <= cur_dc_next;
      cur_mio_reg <= cur_mio_next;
      cur_lock_reg <= cur_lock_next;
      cur_last_reg <= cur_last_next;
      cur_split_reg <= cur_split_next;
      split2_reg <= split2_next;
      cur_irq_reg <= cur_irq_next;
      cur_core_reg <= cur_core_next;
      wdata_reg <= wdata_next;
      beat_reg <= beat_next;
      lock_n_reg <= lock_n_next;
      addr_reg <= addr_next;
      be_reg <= be_next;
      dc_reg <= dc_next;
      mio_reg <= mio_next;
      wr_reg <= wr_next;
      split_cycle_ind_reg <= split_cycle_ind_next;
      dout_reg <= dout_next;
      rdata_reg <= rdata_next;
      done_reg <= done_next;
      cach_reg <= cach_next;
      vec_reg <= vec_next;
      vec_v_reg <= vec_v_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pins
  assign addr_out = addr_reg;
  assign addr_parity = ^addr_reg;
  // address floats while hold is sampled
  // so a writeback under hold leaves it undriven
  assign addr_oe_n = ah_s_reg || state_reg == cbs_pkg::CBS_HOLD;
  assign addr_strobe_n = !(state_reg == cbs_pkg::CBS_T1);
  assign byte_enables_n = be_reg;
  assign data_code_sel = dc_reg;
  assign mem_io_sel = mio_reg;
  assign write_read_sel = wr_reg;
  assign bus_lock_n = lock_n_reg;
  assign split_cycle_ind = split_cycle_ind_reg;
  assign ctrl_oe_n = state_reg == cbs_pkg::CBS_HOLD;
  assign data_out = dout_reg;
  assign data_oe_n = !(wr_reg && (state_reg == cbs_pkg::CBS_T1 ||
                                  state_reg == cbs_pkg::CBS_T2));
  assign snoop_hit_n = hit_n_reg;
  assign snoop_dirty_hit_n = dhit_n_reg;
  assign line_upd = upd_reg;
  assign line_upd_inv = upd_inv_reg;
  assign line_upd_addr = snp_reg;
  assign req_done = done_reg;
  assign rd_data = rdata_reg;
  assign rd_cacheable = cach_reg;
  assign irq_vec_valid = vec_v_reg;
  assign irq_vec = vec_reg;
endmodule
`default_nettype wire

// *** testbench/cbs_bus_unit_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
module cbs_bus_unit_checker (
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire logic addr_hold_req, // hold
  input wire logic ext_addr_strobe_n, // snoop strobe
  input wire logic snoop_invalidate, // invalidate
  input wire logic backoff_n, // backoff
  input wire logic lookup_hit, // hit
  input wire logic lookup_dirty, // dirty
  input wire logic addr_oe_n, // addr enable
  input wire logic [31:3] addr_out, // addr
  input wire logic addr_strobe_n, // strobe
  input wire logic [7:0] byte_enables_n, // enables
  input wire logic data_code_sel, // d/c
  input wire logic mem_io_sel, // m/io
  input wire logic write_read_sel, // w/r
  input wire logic bus_lock_n, // lock
  input wire logic ctrl_oe_n, // ctrl enable
  input wire logic snoop_hit_n, // hit out
  input wire logic snoop_dirty_hit_n, // dirty out
  input wire logic line_upd, // update
  input wire logic line_upd_inv, // update kind
  input wire logic req_done // done
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  snoop_clean_a: assert property (
    $past(addr_hold_req) && $past(addr_hold_req, 2) && !ext_addr_strobe_n
    && lookup_hit && !lookup_dirty |=> !snoop_hit_n && snoop_dirty_hit_n)
    else $error("clean snoop answer wrong");
  snoop_dirty_a: assert property (
    $past(addr_hold_req) && $past(addr_hold_req, 2) && !ext_addr_strobe_n
    && lookup_hit && lookup_dirty |=> !snoop_hit_n && !snoop_dirty_hit_n)
    else $error("dirty snoop answer wrong");
  line_state_a: assert property (
    $past(addr_hold_req) && $past(addr_hold_req, 2) && !ext_addr_strobe_n
    && lookup_hit && !lookup_dirty
    |=> line_upd && line_upd_inv == $past(snoop_invalidate))
    else $error("line state update wrong");
  addr_float_a: assert property (
    addr_hold_req |=> addr_oe_n)
    else $error("address driven under hold");
  backoff_abort_a: assert property (
    !backoff_n && $past(addr_strobe_n) == 1'b0 |=> ctrl_oe_n && !req_done)
    else $error("backoff did not abort");
  restart_drive_a: assert property (
    ctrl_oe_n && backoff_n |=> !ctrl_oe_n && !addr_strobe_n)
    else $error("no restart after backoff");
  lock_start_a: assert property (
    $fell(bus_lock_n) |-> !addr_strobe_n)
    else $error("lock not with strobe");
  irq_cycle_a: assert property (
    !addr_strobe_n && !bus_lock_n && byte_enables_n == 8'hFE
    |-> addr_out == 29'h0000_0000 && !write_read_sel && !mem_io_sel
    && !data_code_sel)
    else $error("acknowledge cycle fields wrong");
  wb_first_a: assert property (
    !addr_strobe_n && !snoop_dirty_hit_n
    |-> byte_enables_n == 8'h00 && write_read_sel)
    else $error("cycle before writeback");
  wb_update_a: assert property (
    $rose(snoop_dirty_hit_n) |-> line_upd)
    else $error("update not after writeback");
endmodule
`default_nettype wire

// *** testbench/cbs_bus_unit_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module cbs_bus_unit_tb;
  logic clk, rst_n, addr_hold_req, ext_addr_strobe_n, snoop_invalidate;
  logic backoff_n, lookup_hit, lookup_dirty, req_valid, req_write, req_lock;
  logic req_lock_last, req_split, lock_flush_done, maskable_irq;
  logic irq_boundary, ken_n, flush_seen, burst_ready_n, cache_enable_n;
  logic addr_parity, addr_oe_n, addr_strobe_n, data_code_sel, mem_io_sel;
  logic write_read_sel, bus_lock_n, split_cycle_ind, ctrl_oe_n, data_oe_n;
  logic snoop_hit_n, snoop_dirty_hit_n, line_upd, line_upd_inv, req_ready;
  logic lock_flush_req, req_done, rd_cacheable, irq_vec_valid;
  logic [31:3] addr_in, req_addr, addr_out;
  logic [31:5] line_upd_addr;
  logic [7:0] req_be_n, req_be2_n, vec, byte_enables_n, irq_vec;
  logic [1:0] waits;
  logic [255:0] wb_line;
  logic [63:0] req_wdata, data_in, data_out, rd_data;
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  cbs_chipset_model partner (.*);
  cbs_bus_unit uut (.ce(1'b1), .req_dc(1'b1), .req_mio(1'b1), .*);
  always #4 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    lock_flush_done <= lock_flush_req;
    if (lock_flush_req === 1'b1)
      flush_seen <= 1'b1;
    if (cyc == 3000)
    begin
      fail_count++;
      end_of_test;
    end
  end
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [95:0] s, e);
    tests_run++;
    if (s !== e)
    begin
      $display("ERROR %s expected %h seen %h", n, e, s);
      fail_count++;
    end
  endtask
  task automatic fin(input string n);
    $display("test %s done, mismatches %0d", n, fail_count);
  endtask
  task automatic req_go(input logic [31:3] a, input logic [7:0] be, be2,
    input logic w, lk, lst, sp);
    @(posedge clk);
    {req_valid, req_addr, req_be_n, req_be2_n, req_wdata} <=
      {1'b1, a, be, be2, 35'h0, a};
    {req_write, req_lock, req_lock_last, req_split} <= {w, lk, lst, sp};
    repeat (40)
    begin
      @(negedge clk);
      if (req_ready === 1'b1) break;
    end
    @(posedge clk);
    req_valid <= 1'b0;
  endtask
  task automatic req_end;
    repeat (60)
    begin
      @(negedge clk);
      if (req_done === 1'b1) break;
    end
    chk("req_done", req_done, 1'b1);
  endtask
  task automatic stb(input logic [31:3] a, input logic [7:0] be,
    input logic w);
    repeat (40)
    begin
      @(negedge clk);
      if (addr_strobe_n === 1'b0) break;
    end
    chk("cycle", {addr_strobe_n, addr_out, byte_enables_n, write_read_sel},
      {1'b0, a, be, w});
  endtask
  task automatic snoop(input logic [31:3] a, input logic d, v, ah);
    @(posedge clk);
    addr_hold_req <= ah;
    repeat (2) @(posedge clk);
    {ext_addr_strobe_n, addr_in, lookup_hit, lookup_dirty} <= {1'b0, a, 1'b1, d};
    snoop_invalidate <= v;
    @(posedge clk);
    {ext_addr_strobe_n, addr_in} <= {1'b1, ~a};
    @(negedge clk);
    chk("hit", {snoop_hit_n, snoop_dirty_hit_n}, {1'b0, !d});
    if (ah)
      chk("aoe", addr_oe_n, 1'b1);
  endtask
  task automatic t_lock;
    @(posedge clk);
    waits <= 2'h2;
    req_go(29'h0000_0100, 8'hF0, 8'hFF, 1'b0, 1'b0, 1'b0, 1'b0);
    req_end;
    chk("rdata", {rd_cacheable, rd_data}, {1'b1, 56'h13_5790_2468_ace0, vec});
    req_go(29'h0000_0200, 8'h0F, 8'hFF, 1'b0, 1'b1, 1'b0, 1'b0);
    stb(29'h0000_0200, 8'h0F, 1'b0);
    chk("lock", bus_lock_n, 1'b0);
    req_end;
    chk("nocache", {rd_cacheable, flush_seen, bus_lock_n}, 3'h2);
    req_go(29'h0000_0208, 8'h0F, 8'hFF, 1'b1, 1'b1, 1'b1, 1'b0);
    req_end;
    chk("unlock", bus_lock_n, 1'b1);
    waits <= 2'h0;
    fin("lock");
  endtask
  task automatic t_snoop;
    for (int v = 0; v < 2; v++)
    begin
      snoop(29'h0000_1000 + 29'(4 * v), 1'b0, v[0], 1'b1);
      chk("upd", {line_upd, line_upd_inv, line_upd_addr},
        {1'b1, v[0], 27'h000_0400 + 27'(v)});
    end
    fork
      req_go(29'h0000_0400, 8'hF0, 8'hFF, 1'b0, 1'b0, 1'b0, 1'b0);
      begin
        repeat (3) @(negedge clk);
        chk("refuse", req_ready, 1'b0);
        @(posedge clk);
        addr_hold_req <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        chk("start", addr_strobe_n, 1'b0);
      end
    join
    req_end;
    chk("stand", snoop_hit_n, 1'b0);
    fin("snoop");
  endtask
  task automatic t_dirty;
    snoop(29'h0000_2000, 1'b1, 1'b0, 1'b1);
    chk("early", line_upd, 1'b0);
    @(posedge clk);
    addr_hold_req <= 1'b0;
    stb(29'h0000_2000, 8'h00, 1'b1);
    for (int k = 0; k < 4; k++)
    begin
      repeat (10)
      begin
        @(negedge clk);
        if (burst_ready_n === 1'b0) break;
      end
      chk("wbdat", data_out, wb_line[64 * k +: 64]);
    end
    @(negedge clk);
    chk("after", {snoop_dirty_hit_n, line_upd, line_upd_inv}, 3'h6);
    fin("dirty");
  endtask
  task automatic t_backoff_n;
    req_go(29'h0000_0300, 8'h3C, 8'hFF, 1'b0, 1'b1, 1'b0, 1'b0);
    stb(29'h0000_0300, 8'h3C, 1'b0);
    @(posedge clk);
    backoff_n <= 1'b0;
    repeat (2) @(negedge clk);
    chk("abort", {ctrl_oe_n, req_done}, 2'h2);
    snoop(29'h0000_4000, 1'b1, 1'b1, 1'b0);
    @(posedge clk);
    backoff_n <= 1'b1;
    stb(29'h0000_4000, 8'h00, 1'b1);
    chk("wblock", bus_lock_n, 1'b0);
    stb(29'h0000_0300, 8'h3C, 1'b0);
    req_end;
    req_go(29'h0000_0308, 8'h3C, 8'hFF, 1'b1, 1'b1, 1'b1, 1'b0);
    req_end;
    fin("backoff");
  endtask
  task automatic t_split;
    req_go(29'h0000_0500, 8'h3F, 8'hFC, 1'b1, 1'b1, 1'b1, 1'b1);
    stb(29'h0000_0500, 8'h3F, 1'b1);
    chk("split", {split_cycle_ind, bus_lock_n}, 2'h2);
    stb(29'h0000_0501, 8'hFC, 1'b1);
    chk("split2", split_cycle_ind, 1'b1);
    req_end;
    fin("split");
  endtask
  task automatic t_irq;
    @(posedge clk);
    {maskable_irq, irq_boundary} <= 2'h3;
    @(posedge clk);
    irq_boundary <= 1'b0;
    stb(29'h0000_0000, 8'hEF, 1'b0);
    chk("ia", {bus_lock_n, mem_io_sel, data_code_sel}, 3'h0);
    stb(29'h0000_0000, 8'hFE, 1'b0);
    repeat (20)
    begin
      @(negedge clk);
      if (irq_vec_valid === 1'b1) break;
    end
    chk("vec", {irq_vec_valid, irq_vec}, {1'b1, vec});
    @(posedge clk);
    maskable_irq <= 1'b0;
    fin("irq");
  endtask
  initial
  begin
    {clk, rst_n, addr_hold_req, ext_addr_strobe_n, snoop_invalidate} = 5'h2;
    {backoff_n, lookup_hit, lookup_dirty, req_valid, req_write} = 5'h10;
    {req_lock, req_lock_last, req_split, lock_flush_done} = 4'h0;
    {maskable_irq, irq_boundary, ken_n, flush_seen} = 4'h0;
    {addr_in, req_addr, req_be_n, req_be2_n, req_wdata} = '0;
    {vec, waits} = {8'h5A, 2'h0};
    wb_line = {64'h4, 64'h3, 64'h2, 64'h1};
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("reset", {addr_strobe_n, bus_lock_n, byte_enables_n, snoop_hit_n,
      snoop_dirty_hit_n, data_oe_n, ctrl_oe_n}, 14'h3FFE);
    t_lock;
    t_snoop;
    t_dirty;
    t_backoff_n;
    t_split;
    t_irq;
    end_of_test;
  end
endmodule
bind cbs_bus_unit cbs_bus_unit_checker chk_i (.*);
`default_nettype wire

// *** testbench/cbs_chipset_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module cbs_chipset_model (
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire logic addr_strobe_n, // strobe
  input wire logic ctrl_oe_n, // bus hold
  input wire logic write_read_sel, // write
  input wire logic [7:0] byte_enables_n, // enables
  input wire logic [1:0] waits, // wait states
  input wire logic ken_n, // cache level
  input wire logic [7:0] vec, // vector
  output logic burst_ready_n, // ready
  output logic cache_enable_n, // cacheable
  output logic [63:0] data_in // read data
);
  logic busy_reg;
  logic [1:0] wait_reg;
  logic [1:0] left_reg;
  logic [63:0] rdat;
  assign rdat = {56'h13_5790_2468_ace0, vec};
  assign cache_enable_n = ken_n;
  assign burst_ready_n = !(busy_reg && wait_reg == 2'h0 && !ctrl_oe_n);
  assign data_in = burst_ready_n ? ~rdat : rdat;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_reg <= 1'b0;
      wait_reg <= 2'h0;
      left_reg <= 2'h0;
    end
    else if (ctrl_oe_n)
      busy_reg <= 1'b0;
    else if (!addr_strobe_n)
    begin
      busy_reg <= 1'b1;
      wait_reg <= waits;
      left_reg <= write_read_sel && byte_enables_n == 8'h00 ? 2'h3 : 2'h0;
    end
    else if (busy_reg && wait_reg != 2'h0)
      wait_reg <= wait_reg - 2'h1;
    else if (busy_reg && left_reg != 2'h0)
      left_reg <= left_reg - 2'h1;
    else
      busy_reg <= 1'b0;
  end
endmodule
`default_nettype wire
